/* src/uft_pkg.sv */
// Shared constants, types and decode functions of the serial port
package uft_pkg;

    localparam int unsigned ADDR_W = 3;
    localparam int unsigned BAUD_W = 12;

    // Register addresses
    localparam logic [2:0] ADDR_DATA    = 3'h0;
    localparam logic [2:0] ADDR_STATUS  = 3'h1;
    localparam logic [2:0] ADDR_CTRL_B  = 3'h2;
    localparam logic [2:0] ADDR_CTRL_C  = 3'h3;
    localparam logic [2:0] ADDR_BAUD_LO = 3'h4;
    localparam logic [2:0] ADDR_BAUD_HI = 3'h5;

    // Status register bits
    localparam int unsigned ST_RXC  = 7;
    localparam int unsigned ST_TXC  = 6;
    localparam int unsigned ST_UDRE = 5;
    localparam int unsigned ST_FE   = 4;
    localparam int unsigned ST_U2X  = 1;

    // Control register B bits
    localparam int unsigned CB_MASTER = 7;
    localparam int unsigned CB_RXEN   = 4;
    localparam int unsigned CB_TRANSMIT_ENABLE_BIT   = 3;
    localparam int unsigned CB_CSZ2   = 2;
    localparam int unsigned CB_RX9    = 1;
    localparam int unsigned CB_TX9    = 0;

    // Control register C bits
    localparam int unsigned CC_SYNC   = 6;
    localparam int unsigned CC_PAR_HI = 5;
    localparam int unsigned CC_PAR_LO = 4;
    localparam int unsigned CC_STOP   = 3;
    localparam int unsigned CC_CSZ_HI = 2;
    localparam int unsigned CC_CSZ_LO = 1;
    localparam int unsigned CC_POL    = 0;

    // Writable masks and reset values
    localparam logic [7:0]        CTRL_B_MASK = 8'h9D;
    localparam logic [7:0]        CTRL_C_MASK = 8'h7F;
    localparam logic [7:0]        CTRL_B_RST  = 8'h00;
    localparam logic [7:0]        CTRL_C_RST  = 8'h06;
    localparam logic [BAUD_W-1:0] BAUD_RST    = 12'h000;

    // Bit clock divisors applied to the baud tick
    localparam logic [4:0] DIV_NORMAL = 5'h10;
    localparam logic [4:0] DIV_DOUBLE = 5'h08;
    localparam logic [4:0] DIV_SYNC   = 5'h02;

    localparam logic [2:0] CSZ_NINE = 3'h7;

    typedef enum logic [2:0] {
        TX_IDLE   = 3'b000,
        TX_START  = 3'b001,
        TX_DATA   = 3'b010,
        TX_PARITY = 3'b011,
        TX_STOP1  = 3'b100,
        TX_STOP2  = 3'b101
    } uft_tx_state_t;

    typedef enum logic [2:0] {
        RX_IDLE   = 3'b000,
        RX_START  = 3'b001,
        RX_DATA   = 3'b010,
        RX_PARITY = 3'b011,
        RX_STOP   = 3'b100
    } uft_rx_state_t;

    // Character size code to data bit count; reserved codes fall back to 8
    function automatic logic [3:0] uft_char_bits(input logic [2:0] csz);
        case (csz)
            3'h0:     uft_char_bits = 4'h5;
            3'h1:     uft_char_bits = 4'h6;
            3'h2:     uft_char_bits = 4'h7;
            3'h3:     uft_char_bits = 4'h8;
            CSZ_NINE: uft_char_bits = 4'h9;
            default:  uft_char_bits = 4'h8;
        endcase
    endfunction

    function automatic logic [8:0] uft_char_mask(input logic [3:0] nbits);
        uft_char_mask = 9'h1FF >> (4'h9 - nbits);
    endfunction

endpackage

/* src/uft_baud_gen.sv */
// Reloading down-counter that makes the baud tick
`timescale 1ns/1ps
`default_nettype none
module uft_baud_gen
#(
    parameter int unsigned DIV_W = uft_pkg::BAUD_W
)
(
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Divisor control
    input  wire logic [DIV_W-1:0] divisor,
    input  wire logic             reload,
    // Tick out, one cycle every divisor+1 cycles
    output logic                  tick
);
    import uft_pkg::*;

    typedef struct packed {
        logic [DIV_W-1:0] cnt;
        logic             tick;
    } uft_bg_t;

    uft_bg_t r, n;

    always_comb
    begin
        n = r;
        n.tick = 1'b0;
        if (reload)
        begin
            n.cnt = divisor;
        end
        else if (r.cnt == '0)
        begin
            n.cnt = divisor;
            n.tick = 1'b1;
        end
        else
        begin
            n.cnt = r.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            r <= '0;
        else
            r <= n;
    end

    assign tick = r.tick;

endmodule
`default_nettype wire

/* src/uft_edge_sync.sv */
// Two-stage synchroniser with rise and fall detection
`timescale 1ns/1ps
`default_nettype none
module uft_edge_sync
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Pin in
    input  wire logic pin_in,
    // Edge pulses
    output logic      rise,
    output logic      fall
);
    typedef struct packed {
        logic meta;
        logic stable;
        logic last;
        logic rise;
        logic fall;
    } uft_es_t;

    uft_es_t r, n;

    // The first stage feeds only the second one
    always_comb
    begin
        n = r;
        n.meta = pin_in;
        n.stable = r.meta;
        n.last = r.stable;
        n.rise = r.stable & ~r.last;
        n.fall = ~r.stable & r.last;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            r <= '0;
        else
            r <= n;
    end

    assign rise = r.rise;
    assign fall = r.fall;

endmodule
`default_nettype wire

/* src/uft_usart.sv */
// Serial port core: registers, frame transmitter, frame receiver
// How it works
// - Sync mode: transfer clock pin is input as slave, output as master
// - Sync input is sampled on the edge opposite the data change edge
// - Polarity clear: change on rising, sample falling; set: the reverse
// - All thirty frame formats: 5 to 9 bits, parity options, 1-2 stops
// - Frame order: start, data LSB first, optional parity, stop bits
// - After a frame, next frame follows at once or line idles high
// - Start bit is always low, stop bits always high
// - Transmitter and receiver share one frame format setting
// - Receiver ignores second stop bit; frame error only on first stop
// - Parity is XOR of data bits, inverted for odd parity
// - Transmit enable hands the transmit pin to the serial output
// - Sync master mode with transmitter or receiver on takes over the transfer clock pin
// - Writing the data register with transmit enable set loads the buffer and starts sending
// - Buffer moves to shifter when idle or right after last stop bit
// - Shifter sends a frame at baud generator or external clock rate
// - Data bits above the character size are dropped, never sent
// - Buffer empty flag clears on data write, sets when buffer moves
// - Complete flag sets after frame with empty buffer; write one clears
// - Disabling waits for pending frames, then releases the pin
// - Bit clock divides baud tick by 16, 8 or 2 by mode
//
// The strobed register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module uft_usart
(
    // Clock and reset
    input  wire logic                       clk,
    input  wire logic                       rst,
    // Register port
    input  wire logic [uft_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [7:0]                 reg_wdata,
    input  wire logic                       reg_we,
    input  wire logic                       reg_re,
    output logic      [7:0]                 reg_rdata,
    // Serial data pins
    input  wire logic                       serial_in_pin,
    output logic                            serial_out_pin,
    output logic                            serial_out_oe,
    // Transfer clock pin
    input  wire logic                       transfer_clock_in,
    output logic                            transfer_clock_out,
    output logic                            transfer_clock_oe
);
    import uft_pkg::*;

    typedef struct packed {
        logic [7:0]        ctrl_b;
        logic [7:0]        ctrl_c;
        logic              u2x;
        logic [BAUD_W-1:0] baud;
        logic [8:0]        tx_buf;
        logic              tx_full;
        logic              txc;
        uft_tx_state_t     tx_state;
        logic [8:0]        tx_sh;
        logic [3:0]        tx_cnt;
        logic              tx_par;
        logic              txd;
        logic              txd_oe;
        logic [3:0]        pre_cnt;
        logic              xck_o;
        logic              xck_oe;
        uft_rx_state_t     rx_state;
        logic [3:0]        rx_os;
        logic [3:0]        rx_cnt;
        logic [8:0]        rx_sh;
        logic [8:0]        rx_buf;
        logic              rx_complete_flag;
        logic              fe;
        logic [7:0]        rdata;
    } uft_core_t;

    localparam uft_core_t CORE_RST = '{
        ctrl_b:   CTRL_B_RST,
        ctrl_c:   CTRL_C_RST,
        baud:     BAUD_RST,
        tx_state: TX_IDLE,
        rx_state: RX_IDLE,
        txd:      1'b1,
        default:  '0
    };

    uft_core_t         r;
    uft_core_t         n;
    logic              sync_mode;
    logic              clk_master;
    logic              pol;
    logic              two_stop;
    logic              par_on;
    logic              par_odd;
    logic [3:0]        nbits;
    logic [8:0]        cmask;
    logic [4:0]        div;
    logic              baud_tick;
    logic              baud_load;
    logic [BAUD_W-1:0] baud_div;
    logic              x_rise;
    logic              x_fall;
    logic              chg_ev;
    logic              smp_ev;
    logic              tx_tick;
    logic              rx_samp;
    logic              data_wr;
    logic              fin;
    logic              load;

    // One format decode serves both directions
    assign sync_mode  = r.ctrl_c[CC_SYNC];
    assign clk_master = sync_mode & r.ctrl_b[CB_MASTER];
    assign pol        = r.ctrl_c[CC_POL];
    assign two_stop   = r.ctrl_c[CC_STOP];
    assign par_on     = r.ctrl_c[CC_PAR_HI];
    assign par_odd    = r.ctrl_c[CC_PAR_LO];
    assign nbits      = uft_char_bits({r.ctrl_b[CB_CSZ2],
                        r.ctrl_c[CC_CSZ_HI:CC_CSZ_LO]});
    assign cmask      = uft_char_mask(nbits);

    // Baud tick divided per mode
    assign div = sync_mode ? DIV_SYNC
               : (r.u2x ? DIV_DOUBLE : DIV_NORMAL);

    // A low byte write reloads the counter with the new value at once
    assign baud_load = reg_we && (reg_addr == ADDR_BAUD_LO);
    assign baud_div  = baud_load ? {r.baud[BAUD_W-1:8], reg_wdata}
                                 : r.baud;

    // Data changes on one transfer clock edge and is sampled on the other
    assign chg_ev = clk_master ? (baud_tick && (r.xck_o == pol))
                               : (pol ? x_fall : x_rise);
    assign smp_ev = clk_master ? (baud_tick && (r.xck_o != pol))
                               : (pol ? x_rise : x_fall);

    assign tx_tick = sync_mode ? chg_ev
                   : (baud_tick
                      && ({1'b0, r.pre_cnt} == div - 5'h01));
    assign rx_samp = sync_mode ? smp_ev
                   : (baud_tick
                      && ({1'b0, r.rx_os} == (div >> 1) - 5'h01));

    assign data_wr = reg_we && (reg_addr == ADDR_DATA);

    always_comb
    begin
        logic [7:0] st;
        st = 8'h00;
        n = r;
        fin = 1'b0;
        load = 1'b0;
        n.rdata = 8'h00;

        // Reads come first so a frame finishing now sets its flag again
        if (reg_re)
        begin
            st[ST_RXC]  = r.rx_complete_flag;
            st[ST_TXC]  = r.txc;
            st[ST_UDRE] = ~r.tx_full;
            st[ST_FE]   = r.fe;
            st[ST_U2X]  = r.u2x;
            case (reg_addr)
                ADDR_DATA:
                begin
                    n.rdata = r.rx_buf[7:0];
                    n.rx_complete_flag = 1'b0;
                end
                ADDR_STATUS:  n.rdata = st;
                ADDR_CTRL_B:  n.rdata = r.ctrl_b
                                        | {6'h00, r.rx_buf[8], 1'b0};
                ADDR_CTRL_C:  n.rdata = r.ctrl_c;
                ADDR_BAUD_LO: n.rdata = r.baud[7:0];
                ADDR_BAUD_HI: n.rdata = {4'h0, r.baud[BAUD_W-1:8]};
                default:      n.rdata = 8'h00;
            endcase
        end

        if (reg_we)
        begin
            case (reg_addr)
                ADDR_STATUS:
                begin
                    n.u2x = reg_wdata[ST_U2X];
                    if (reg_wdata[ST_TXC])
                        n.txc = 1'b0;
                end
                ADDR_CTRL_B:  n.ctrl_b = reg_wdata & CTRL_B_MASK;
                ADDR_CTRL_C:  n.ctrl_c = reg_wdata & CTRL_C_MASK;
                ADDR_BAUD_LO: n.baud[7:0] = reg_wdata;
                ADDR_BAUD_HI: n.baud[BAUD_W-1:8] = reg_wdata[3:0];
                default:      n.rdata = n.rdata;
            endcase
        end

        if (baud_tick)
        begin
            if ({1'b0, r.pre_cnt} == div - 5'h01)
                n.pre_cnt = 4'h0;
            else
                n.pre_cnt = r.pre_cnt + 4'h1;
        end

        // Master clock rests at the polarity level, toggles per baud tick
        if (!clk_master)
            n.xck_o = pol;
        else if (baud_tick)
            n.xck_o = ~r.xck_o;

        // Transmit shifter
        if (tx_tick)
        begin
            case (r.tx_state)
                TX_IDLE:  load = r.tx_full;
                TX_START:
                begin
                    n.txd = r.tx_sh[0];
                    n.tx_sh = r.tx_sh >> 1;
                    n.tx_cnt = 4'h1;
                    n.tx_state = TX_DATA;
                end
                TX_DATA:
                begin
                    if (r.tx_cnt == nbits)
                    begin
                        n.txd = par_on ? r.tx_par : 1'b1;
                        n.tx_state = par_on ? TX_PARITY : TX_STOP1;
                    end
                    else
                    begin
                        n.txd = r.tx_sh[0];
                        n.tx_sh = r.tx_sh >> 1;
                        n.tx_cnt = r.tx_cnt + 4'h1;
                    end
                end
                TX_PARITY:
                begin
                    n.txd = 1'b1;
                    n.tx_state = TX_STOP1;
                end
                TX_STOP1:
                begin
                    if (two_stop)
                        n.tx_state = TX_STOP2;
                    else
                        fin = 1'b1;
                end
                TX_STOP2: fin = 1'b1;
                default:  n.tx_state = TX_IDLE;
            endcase
        end

        // Back-to-back frames when the buffer is already full
        if (fin)
        begin
            if (r.tx_full)
            begin
                load = 1'b1;
            end
            else
            begin
                n.tx_state = TX_IDLE;
                n.txc = 1'b1;
            end
        end

        if (load)
        begin
            n.tx_sh = r.tx_buf & cmask;
            n.tx_par = ^(r.tx_buf & cmask) ^ par_odd;
            n.txd = 1'b0;
            n.tx_full = 1'b0;
            n.tx_state = TX_START;
        end

        // A write after the load in the same cycle refills the buffer
        if (data_wr && r.ctrl_b[CB_TRANSMIT_ENABLE_BIT])
        begin
            n.tx_buf = {r.ctrl_b[CB_TX9], reg_wdata};
            n.tx_full = 1'b1;
        end

        // Pin stays ours until pending frames have left
        n.txd_oe = n.ctrl_b[CB_TRANSMIT_ENABLE_BIT] | n.tx_full
                   | (n.tx_state != TX_IDLE);
        n.xck_oe = clk_master
                   & (r.txd_oe | r.ctrl_b[CB_RXEN]);

        // Receiver
        if (baud_tick && (r.rx_state != RX_IDLE))
        begin
            if ({1'b0, r.rx_os} == div - 5'h01)
                n.rx_os = 4'h0;
            else
                n.rx_os = r.rx_os + 4'h1;
        end

        if (!r.ctrl_b[CB_RXEN])
        begin
            n.rx_state = RX_IDLE;
        end
        else
        begin
            case (r.rx_state)
                RX_IDLE:
                begin
                    if (sync_mode && smp_ev && !serial_in_pin)
                    begin
                        n.rx_state = RX_DATA;
                        n.rx_cnt = 4'h0;
                        n.rx_sh = 9'h000;
                    end
                    else if (!sync_mode && baud_tick && !serial_in_pin)
                    begin
                        n.rx_state = RX_START;
                        n.rx_os = 4'h0;
                    end
                end
                RX_START:
                begin
                    // A high sample at mid start bit was a glitch
                    if (rx_samp)
                    begin
                        n.rx_state = serial_in_pin ? RX_IDLE : RX_DATA;
                        n.rx_cnt = 4'h0;
                        n.rx_sh = 9'h000;
                    end
                end
                RX_DATA:
                begin
                    if (rx_samp)
                    begin
                        n.rx_sh[r.rx_cnt] = serial_in_pin;
                        if (r.rx_cnt == nbits - 4'h1)
                            n.rx_state = par_on ? RX_PARITY : RX_STOP;
                        else
                            n.rx_cnt = r.rx_cnt + 4'h1;
                    end
                end
                RX_PARITY:
                begin
                    if (rx_samp)
                        n.rx_state = RX_STOP;
                end
                RX_STOP:
                begin
                    // Done at the first stop bit; a second one is not looked at
                    if (rx_samp)
                    begin
                        n.rx_buf = r.rx_sh;
                        n.rx_complete_flag = 1'b1;
                        n.fe = ~serial_in_pin;
                        n.rx_state = RX_IDLE;
                    end
                end
                default: n.rx_state = RX_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            r <= CORE_RST;
        else
            r <= n;
    end

    uft_baud_gen #(
        .DIV_W   (BAUD_W)
    ) u_baud (
        .clk     (clk),
        .rst     (rst),
        .divisor (baud_div),
        .reload  (baud_load),
        .tick    (baud_tick)
    );

    // External clock costs three cycles of delay through the synchroniser
    uft_edge_sync u_xck (
        .clk     (clk),
        .rst     (rst),
        .pin_in  (transfer_clock_in),
        .rise    (x_rise),
        .fall    (x_fall)
    );

    assign reg_rdata          = r.rdata;
    assign serial_out_pin     = r.txd;
    assign serial_out_oe      = r.txd_oe;
    assign transfer_clock_out = r.xck_o;
    assign transfer_clock_oe  = r.xck_oe;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    a_start_low:
    assert property (r.tx_state == TX_START |-> !serial_out_pin)
        else $error("start bit not low");
    a_stop_high:
    assert property ((r.tx_state == TX_STOP1 || r.tx_state == TX_STOP2)
                     |-> serial_out_pin)
        else $error("stop bit not high");
    a_idle_high:
    assert property (r.tx_state == TX_IDLE |-> serial_out_pin)
        else $error("idle line not high");
    a_lsb_first:
    assert property ((r.tx_state == TX_START && tx_tick)
                     |=> r.tx_state == TX_DATA
                         && serial_out_pin == $past(r.tx_sh[0]))
        else $error("first data bit is not the LSB");
    a_buffer_moves:
    assert property ((r.tx_state == TX_IDLE && r.tx_full && tx_tick
                      && !data_wr) |=> r.tx_state == TX_START && !r.tx_full)
        else $error("buffer not moved to idle shifter");
    a_write_fills:
    assert property ((data_wr && r.ctrl_b[CB_TRANSMIT_ENABLE_BIT]) |=> r.tx_full)
        else $error("data write left buffer empty");
    a_txc_sets:
    assert property ((fin && !r.tx_full) |=> r.txc ##1 r.txc || $fell(r.txc))
        else $error("complete flag not set");
    a_txc_clears:
    assert property ((reg_we && reg_addr == ADDR_STATUS
                      && reg_wdata[ST_TXC] && !fin) |=> !r.txc)
        else $error("complete flag not cleared");
    a_pin_held:
    assert property ((r.tx_state != TX_IDLE || r.tx_full) |-> serial_out_oe)
        else $error("pin released with frame pending");
    a_parity_out:
    assert property (r.tx_state == TX_PARITY |-> serial_out_pin == r.tx_par)
        else $error("parity bit wrong");
    a_frame_error:
    assert property ((r.rx_state == RX_STOP && rx_samp && r.ctrl_b[CB_RXEN])
                     |=> r.rx_complete_flag && r.fe == !$past(serial_in_pin))
        else $error("frame error does not follow first stop bit");
    a_clock_drive:
    assert property ((clk_master && r.txd_oe) |=> transfer_clock_oe)
        else $error("transfer clock not driven");

    c_back_to_back: cover property (fin && r.tx_full);
    c_two_stop:     cover property (r.tx_state == TX_STOP2 && tx_tick);
    c_rx_frame:     cover property ($rose(r.rx_complete_flag));
    c_sync_slave:   cover property (sync_mode && !clk_master && tx_tick);

endmodule
`default_nettype wire

/* dv/uft_peer.sv */
// Far-side serial receiver that samples the transmit line mid-bit
`timescale 1ns/1ps
`default_nettype none
module uft_peer
(
    // Clock and line
    input  wire logic        clk,
    input  wire logic        line,
    // Bits taken after the start bit
    input  wire logic [3:0]  nbits,
    // Line echoed back, captured frame, toggle per frame
    output logic             serial_in_pin,
    output logic      [12:0] frame,
    output logic             got
);
    // Echo lets the receiver see every frame the transmitter sends
    assign serial_in_pin = line;

    // One bit lasts 16 clocks in every mode the bench uses
    initial
    begin
        got = 1'b0;
        frame = 13'h0000;
        forever
        begin
            @(negedge line);
            repeat (8) @(posedge clk);
            frame = 13'h0000;
            for (int i = 0; i <= nbits; i++)
            begin
                frame[i] = line;
                if (i < nbits) repeat (16) @(posedge clk);
            end
            got = ~got;
        end
    end
endmodule
`default_nettype wire

/* dv/tb.sv */
// Bench: reset values, six frame kinds, buffering, flags
`timescale 1ns/1ps
`default_nettype none
module tb;
    import uft_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [2:0]  reg_addr = 3'h0;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_we = 1'b0;
    logic        reg_re = 1'b0;
    logic [7:0]  reg_rdata;
    logic        sin;
    logic        sout;
    logic        sout_oe;
    logic        xck;
    logic        xck_oe;
    logic [3:0]  nbits = 4'h9;
    logic [12:0] frame;
    logic        got;
    logic [12:0] exp_f;
    logic [8:0]  exp_d;
    int          error_cnt = 0;
    int          checks_done = 0;
    int          cyc = 0;
    int          n;
    int          k;
    logic [2:0]  csz_tab [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7, 3'h3};
    logic [1:0]  par_tab [6] = '{2'h2, 2'h3, 2'h0, 2'h2, 2'h3, 2'h1};
    logic        stp_tab [6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
    logic [8:0]  dat_tab [6] = '{9'h0FF, 9'h0A5, 9'h0BC, 9'h081, 9'h1A5,
                                 9'h0C3};

    uft_usart uft_usart_i (.clk(clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
        .reg_rdata(reg_rdata), .serial_in_pin(sin), .serial_out_pin(sout),
        .serial_out_oe(sout_oe), .transfer_clock_in(1'b0),
        .transfer_clock_out(xck), .transfer_clock_oe(xck_oe));
    uft_peer uft_peer_i (.clk(clk), .line(sout), .nbits(nbits),
        .serial_in_pin(sin), .frame(frame), .got(got));

    always #5 clk = ~clk;

    task automatic check(input logic [12:0] seen, input logic [12:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_we    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_we <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_re   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_re <= 1'b0;
        #1;
        check(13'(reg_rdata), 13'(e));
    endtask

    task automatic tally_and_finish();
        if (error_cnt == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            error_cnt++;
            tally_and_finish();
        end
    end

    initial
    begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rd(ADDR_STATUS, 8'h20);
        rd(ADDR_CTRL_B, CTRL_B_RST);
        rd(ADDR_CTRL_C, CTRL_C_RST);
        wr(3'h7, 8'hFF);
        rd(3'h7, 8'h00);
        check(13'(sout_oe), 13'h0);
        for (int j = 0; j < 6; j++)
        begin
            n = (csz_tab[j] == CSZ_NINE) ? 9 : 5 + csz_tab[j];
            exp_f = 13'h0000;
            for (int i = 0; i < n; i++) exp_f[1 + i] = dat_tab[j][i];
            exp_d = dat_tab[j] & ~(9'h1FF << n);
            k = n + 1;
            if (par_tab[j][1])
            begin
                exp_f[k] = ^exp_f[9:1] ^ par_tab[j][0];
                k++;
            end
            exp_f[k] = 1'b1;
            exp_f[k + 1] = stp_tab[j];
            nbits <= 4'(k) + 4'(stp_tab[j]);
            wr(ADDR_CTRL_C, {2'h0, par_tab[j], stp_tab[j], csz_tab[j][1:0],
                1'b0});
            wr(ADDR_CTRL_B, {3'h0, 2'h3, csz_tab[j][2], 1'b0,
                dat_tab[j][8]});
            wr(ADDR_DATA, dat_tab[j][7:0]);
            @(got);
            check(frame, exp_f);
            check(13'(sout_oe), 13'h1);
            repeat (20) @(posedge clk);
            rd(ADDR_STATUS, 8'hE0);
            rd(ADDR_CTRL_B, {3'h0, 2'h3, csz_tab[j][2], exp_d[8],
                dat_tab[j][8]});
            rd(ADDR_DATA, exp_d[7:0]);
            wr(ADDR_STATUS, 8'h40);
            rd(ADDR_STATUS, 8'h20);
        end
        // Second byte waits in the buffer while the first one shifts
        nbits <= 4'h9;
        wr(ADDR_CTRL_C, CTRL_C_RST);
        wr(ADDR_DATA, 8'h5A);
        repeat (20) @(posedge clk);
        wr(ADDR_DATA, 8'h96);
        wr(ADDR_CTRL_B, 8'h00);
        rd(ADDR_STATUS, 8'h00);
        @(got);
        check(frame, {3'h1, 8'h5A, 1'b0});
        check(13'(sout_oe), 13'h1);
        @(got);
        check(frame, {3'h1, 8'h96, 1'b0});
        repeat (20) @(posedge clk);
        check(13'(sout_oe), 13'h0);
        check(13'(sout), 13'h1);
        // Sync master, baud 7: a bit is 16 clocks, mid-bit is a falling edge
        wr(ADDR_BAUD_LO, 8'h07);
        wr(ADDR_CTRL_C, 8'h46);
        wr(ADDR_CTRL_B, 8'h88);
        wr(ADDR_DATA, 8'hC3);
        @(got);
        check(frame, {3'h1, 8'hC3, 1'b0});
        #1;
        check(13'(xck), 13'h0);
        check(13'(xck_oe), 13'h1);
        tally_and_finish();
    end
endmodule
`default_nettype wire
